// ==== src/hbp_pkg.sv ====
// package for the host bus pin port: widths, pin positions, serial frame
// layout and the state records of both access engines.
// assumes one 100 MHz clock and inputs already synchronous to it.
package hbp_pkg;

    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;

    // data pins with a second meaning in serial mode
    localparam int PIN_CPOL = 7;
    localparam int PIN_CPHA = 6;
    localparam int PIN_SWAP = 5;
    localparam int PIN_SCLK = 2;
    localparam int PIN_MOSI = 1;
    localparam int PIN_MISO = 0;

    // serial frame: r/w bit, 13 address bits, burst bit, then 8 data bits
    localparam logic [4:0] SER_RW_POS    = 5'h00;
    localparam logic [4:0] SER_ADDR_POS  = 5'h01;
    localparam logic [4:0] SER_BURST_POS = 5'h0E;
    localparam logic [4:0] SER_DATA_POS  = 5'h0F;
    localparam logic [4:0] SER_LAST_POS  = 5'h16;
    localparam logic [4:0] SER_DONE_POS  = 5'h17;
    localparam logic [3:0] ADDR_TOP      = 4'hC;
    localparam logic [3:0] DATA_TOP      = 4'h7;

    // reset values
    localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [4:0]        CNT_RST  = 5'h00;

    // output enable patterns of the data pins
    localparam logic [DATA_W-1:0] OE_ALL  = 8'hFF;
    localparam logic [DATA_W-1:0] OE_MISO = 8'h01;
    localparam logic [DATA_W-1:0] OE_NONE = 8'h00;

    typedef struct packed {
        logic [4:0]        cnt;
        logic              rw;
        logic              burst;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic              wr;
        logic              rd;
        logic              miso;
        logic              sclk_q;
    } hbp_ser_s;

    typedef struct packed {
        logic              rd_q;
        logic              wr_q;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              reg_wr;
        logic              reg_rd;
        logic [DATA_W-1:0] dout;
        logic [DATA_W-1:0] doe;
    } hbp_par_s;

    // index of a field bit for the k-th bit on the wire
    function automatic logic [3:0] bit_idx(input logic [3:0] k,
                                           input logic [3:0] top,
                                           input logic       msb_first);
        bit_idx = msb_first ? 4'(top - k) : k;
    endfunction

endpackage

// ==== src/hbp_serial.sv ====
// serial access engine of the host port, active while serial mode is selected and chip select is low.
// assumes sclk, mosi and the config levels are synchronous samples and that
// sclk half periods last at least three system clocks.
module hbp_serial
    import hbp_pkg::*;
(
    input  wire logic              clk_sys_i,
    input  wire logic              rst_n_i,
    input  wire logic              active_i,
    input  wire logic              cpol_i,
    input  wire logic              cpha_i,
    input  wire logic              msb_first_i,
    input  wire logic              sclk_i,
    input  wire logic              mosi_i,
    input  wire logic [DATA_W-1:0] rdata_i,
    output logic      [ADDR_W-1:0] addr_o,
    output logic      [DATA_W-1:0] wdata_o,
    output logic                   wr_o,
    output logic                   rd_o,
    output logic                   miso_o
);

    hbp_ser_s s_r;
    hbp_ser_s s_nxt;

    logic rise;
    logic fall;
    logic lead;
    logic sample;
    logic shift;
    // a function result cannot be part-selected, so the indexes live here
    logic [3:0] addr_idx;
    logic [3:0] data_idx;

    always_comb
    begin
        s_nxt       = s_r;
        s_nxt.wr    = 1'b0;
        s_nxt.rd    = 1'b0;
        s_nxt.sclk_q = sclk_i;
        rise   = sclk_i & ~s_r.sclk_q;
        fall   = ~sclk_i & s_r.sclk_q;
        lead   = cpol_i ? fall : rise;
        sample = cpha_i ? (rise | fall) & ~lead : lead;
        shift  = (rise | fall) & ~sample;
        addr_idx = bit_idx(4'(s_r.cnt - SER_ADDR_POS), ADDR_TOP, msb_first_i);
        data_idx = bit_idx(4'(s_r.cnt - SER_DATA_POS), DATA_TOP, msb_first_i);
        if (!active_i)
        begin
            s_nxt.cnt = CNT_RST;
        end
        else if (sample && s_r.cnt != SER_DONE_POS)
        begin
            s_nxt.cnt = s_r.cnt + 5'h01;
            if (s_r.cnt == SER_RW_POS)
            begin
                s_nxt.rw = mosi_i;
            end
            else if (s_r.cnt < SER_BURST_POS)
            begin
                // r/w and burst keep their slots; only fields swap order
                s_nxt.addr[addr_idx] = mosi_i;
            end
            else if (s_r.cnt == SER_BURST_POS)
            begin
                s_nxt.burst = mosi_i;
                s_nxt.rd    = s_r.rw;
            end
            else
            begin
                s_nxt.data[data_idx[2:0]] = mosi_i;
                if (s_r.cnt == SER_LAST_POS)
                begin
                    s_nxt.wr = ~s_r.rw;
                    if (s_r.burst)
                    begin
                        s_nxt.cnt  = SER_DATA_POS;
                        s_nxt.addr = s_r.addr + 13'h0001;
                        s_nxt.rd   = s_r.rw;
                    end
                end
            end
        end
        // wire bit k of the data field is placed just before its sample edge
        if (active_i && shift && s_r.rw && s_r.cnt >= SER_DATA_POS
            && s_r.cnt != SER_DONE_POS)
        begin
            s_nxt.miso = rdata_i[data_idx[2:0]];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_r <= '{cnt: CNT_RST, addr: ADDR_RST, data: DATA_RST, default: 1'b0};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign addr_o  = s_r.addr;
    assign wdata_o = s_r.data;
    assign wr_o    = s_r.wr;
    assign rd_o    = s_r.rd;
    assign miso_o  = s_r.miso;

    ser_idle_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !active_i |=> s_r.cnt == CNT_RST && !wr_o)
        else $error("serial engine not idle outside a frame");

    ser_wr_end_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_o |-> $past(s_r.cnt) == SER_LAST_POS && !s_r.rw)
        else $error("serial write not at end of data field");

    ser_rd_pair_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        rd_o |-> s_r.rw && s_r.cnt == SER_DATA_POS)
        else $error("serial read issued outside its slot");

endmodule

// ==== src/hbp_host_port.sv ====
// top of the host bus pin port: 13-bit address, 8-bit two-way data pins,
// strobe decode for both strobe styles, and the serial mode sharing the pins.
// assumes all pins synchronous to clk_sys_i and reg_rdata_i following
// reg_addr_o within the same cycle (plain lookup in the register file).
// How it works
// - decode 13-bit address, addr_msb down to addr_lsb
// - eight data pins: write capture, read drive
// - no data pin driven once chip select has been high for one clock
// - data_bit_seven sets serial clock polarity, the idle level of the clock
// - data_bit_six sets serial sample and shift phase
// - data_bit_five picks field order; r/w, burst fixed
// - pins two, one, zero: clock, in, out
// - strobes honoured only under chip select
module hbp_host_port
    import hbp_pkg::*;
(
    input  wire logic              clk_sys_i,
    input  wire logic              rst_n_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] data_i,
    output logic      [DATA_W-1:0] data_o,
    output logic      [DATA_W-1:0] data_oe_o,
    input  wire logic              chip_select_n_i,
    input  wire logic              read_strobe_n_i,
    input  wire logic              write_strobe_n_i,
    input  wire logic              strobe_style_i,
    input  wire logic              serial_sel_i,
    output logic      [ADDR_W-1:0] reg_addr_o,
    output logic      [DATA_W-1:0] reg_wdata_o,
    output logic                   reg_wr_o,
    output logic                   reg_rd_o,
    input  wire logic [DATA_W-1:0] reg_rdata_i
);

    hbp_par_s p_r;
    hbp_par_s p_nxt;

    logic              sel;
    logic              par_sel;
    logic              rd_act;
    logic              wr_act;
    logic              ser_active;
    logic [ADDR_W-1:0] ser_addr;
    logic [DATA_W-1:0] ser_wdata;
    logic              ser_wr;
    logic              ser_rd;
    logic              ser_miso;

    // serial selections are used live, so they must not move mid-frame
    assign ser_active = serial_sel_i & ~chip_select_n_i;

    hbp_serial u_serial
    (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n_i),
        .active_i    (ser_active),
        .cpol_i      (data_i[PIN_CPOL]),
        .cpha_i      (data_i[PIN_CPHA]),
        .msb_first_i (data_i[PIN_SWAP]),
        .sclk_i      (data_i[PIN_SCLK]),
        .mosi_i      (data_i[PIN_MOSI]),
        .rdata_i     (reg_rdata_i),
        .addr_o      (ser_addr),
        .wdata_o     (ser_wdata),
        .wr_o        (ser_wr),
        .rd_o        (ser_rd),
        .miso_o      (ser_miso)
    );

    always_comb
    begin
        p_nxt        = p_r;
        sel          = ~chip_select_n_i;
        par_sel      = sel & ~serial_sel_i;
        // style 0: separate read and write strobes
        // style 1: data strobe plus read/write level
        if (strobe_style_i)
        begin
            rd_act = par_sel & ~read_strobe_n_i & write_strobe_n_i;
            wr_act = par_sel & ~read_strobe_n_i & ~write_strobe_n_i;
        end
        else
        begin
            rd_act = par_sel & ~read_strobe_n_i;
            wr_act = par_sel & ~write_strobe_n_i & read_strobe_n_i;
        end
        p_nxt.rd_q = rd_act;
        p_nxt.wr_q = wr_act;
        if (serial_sel_i)
        begin
            p_nxt.addr   = ser_addr;
            p_nxt.wdata  = ser_wdata;
            p_nxt.reg_wr = ser_wr;
            p_nxt.reg_rd = ser_rd;
        end
        else
        begin
            if (rd_act || wr_act)
            begin
                p_nxt.addr = addr_i;
            end
            if (wr_act)
            begin
                p_nxt.wdata = data_i;
            end
            // commit writes at the end of the strobe, when the host data is settled; reads are issued at its start
            p_nxt.reg_wr = p_r.wr_q & ~wr_act;
            p_nxt.reg_rd = rd_act & ~p_r.rd_q;
        end
        if (serial_sel_i)
        begin
            p_nxt.dout = {{(DATA_W-1){1'b0}}, ser_miso};
            p_nxt.doe  = sel ? OE_MISO : OE_NONE;
        end
        else
        begin
            p_nxt.dout = reg_rdata_i;
            p_nxt.doe  = rd_act ? OE_ALL : OE_NONE;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            p_r <= '{addr: ADDR_RST, wdata: DATA_RST, dout: DATA_RST,
                     doe: OE_NONE, default: 1'b0};
        end
        else
        begin
            p_r <= p_nxt;
        end
    end

    assign data_o      = p_r.dout;
    assign data_oe_o   = p_r.doe;
    assign reg_addr_o  = p_r.addr;
    assign reg_wdata_o = p_r.wdata;
    assign reg_wr_o    = p_r.reg_wr;
    assign reg_rd_o    = p_r.reg_rd;

    // one cycle of pin latency is the price of registered outputs
    cs_float_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        chip_select_n_i |=> data_oe_o == OE_NONE)
        else $error("data pins driven while chip select high");

    par_read_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !serial_sel_i && !chip_select_n_i && !read_strobe_n_i
        && (strobe_style_i ? write_strobe_n_i : 1'b1)
        |=> data_oe_o == OE_ALL && data_o == $past(reg_rdata_i))
        else $error("read cycle did not drive the register contents");

    rd_start_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !serial_sel_i && $fell(chip_select_n_i | read_strobe_n_i)
        && !strobe_style_i && $past(serial_sel_i) == 1'b0
        |=> reg_rd_o && reg_addr_o == $past(addr_i))
        else $error("read start missed or wrong address");

    wr_commit_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !serial_sel_i && p_r.wr_q && !wr_act
        |=> reg_wr_o && reg_wdata_o == $past(p_r.wdata)
        ##1 !reg_wr_o)
        else $error("write not committed once at strobe end");

    no_strobe_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        chip_select_n_i [*2] |=> !reg_wr_o && !reg_rd_o)
        else $error("strobe honoured without chip select");

    ser_pins_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        serial_sel_i && !chip_select_n_i |=> data_oe_o == OE_MISO)
        else $error("serial mode must drive only the data output pin");

endmodule

// ==== verif/hbp_reg_model.sv ====
// register file standing behind the host port, plain lookup on read
// assumes writes are one-cycle pulses with address and data valid
module hbp_reg_model
    import hbp_pkg::*;
(
    input  wire logic              clk_sys_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    output logic      [DATA_W-1:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] mem [2**ADDR_W];
    initial
    begin
        foreach (mem[i]) mem[i] = 8'h00;
    end
    // every one of the 8192 places is distinct, so aliasing shows
    assign rdata_o = mem[addr_i];
    always @(posedge clk_sys_i)
    begin
        if (wr_i === 1'b1)
            mem[addr_i] <= wdata_i;
    end
endmodule

// ==== verif/testbench.sv ====
// self-checking bench for the host port: parallel rows, serial frames, reset
// assumes weak pull-ups on the data pins while nobody drives them
module testbench
    import hbp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic        sty;
        logic        csn;
        logic        wr;
        logic [12:0] a;
        logic [7:0]  d;
    } hbp_row_s;
    logic              clk_sys = 1'b0;
    logic              rst_n = 1'b0;
    logic              cs_n = 1'b1;
    logic              rd_n = 1'b1;
    logic              wr_n = 1'b1;
    logic              style = 1'b0;
    logic              ser = 1'b0;
    logic              reg_wr;
    logic              reg_rd;
    logic [1:0]        cs_q = 2'h0;
    logic [ADDR_W-1:0] addr = 13'h0000;
    logic [ADDR_W-1:0] reg_addr;
    logic [ADDR_W-1:0] wr_addr;
    logic [ADDR_W-1:0] rd_addr;
    logic [DATA_W-1:0] host_d = 8'h00;
    logic [DATA_W-1:0] host_oe = 8'h00;
    logic [DATA_W-1:0] data_w;
    logic [DATA_W-1:0] data_o;
    logic [DATA_W-1:0] data_oe;
    logic [DATA_W-1:0] reg_wdata;
    logic [DATA_W-1:0] reg_rdata;
    logic [DATA_W-1:0] wr_data;
    int                miscompares = 0;
    int                num_checks = 0;
    int                wr_cnt = 0;
    int                rd_cnt = 0;
    int                oe_err = 0;
    hbp_row_s          rows [9] = '{
        '{1'b0, 1'b0, 1'b1, 13'h1FFF, 8'hA5}, '{1'b0, 1'b0, 1'b0, 13'h1FFF, 8'hA5},
        '{1'b1, 1'b0, 1'b1, 13'h0000, 8'h3C}, '{1'b1, 1'b0, 1'b0, 13'h0000, 8'h3C},
        '{1'b0, 1'b1, 1'b1, 13'h0000, 8'hFF}, '{1'b1, 1'b1, 1'b0, 13'h0000, 8'h3C},
        '{1'b0, 1'b0, 1'b0, 13'h0000, 8'h3C}, '{1'b1, 1'b0, 1'b1, 13'h1555, 8'h81},
        '{1'b0, 1'b0, 1'b0, 13'h1555, 8'h81}};

    always #5 clk_sys = ~clk_sys;
    assign data_w = (data_oe & data_o) | (~data_oe & ((host_oe & host_d) | ~host_oe));

    hbp_host_port uut (
        .clk_sys_i(clk_sys), .rst_n_i(rst_n), .addr_i(addr), .data_i(data_w),
        .data_o(data_o), .data_oe_o(data_oe), .chip_select_n_i(cs_n),
        .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n), .strobe_style_i(style),
        .serial_sel_i(ser), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
        .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata));
    hbp_reg_model regs (
        .clk_sys_i(clk_sys), .addr_i(reg_addr), .wdata_i(reg_wdata),
        .wr_i(reg_wr), .rdata_o(reg_rdata));

    // pins must be released once chip select has been high two edges
    always @(posedge clk_sys)
    begin
        cs_q <= {cs_q[0], cs_n};
        if (rst_n && (&cs_q) && data_oe !== 8'h00)
            oe_err++;
        if (reg_wr === 1'b1)
        begin
            wr_cnt++;
            wr_addr = reg_addr;
            wr_data = reg_wdata;
        end
        if (reg_rd === 1'b1)
        begin
            rd_cnt++;
            rd_addr = reg_addr;
        end
    end

    task automatic fail(input string m);
        miscompares++;
        $display("mismatch at %0t: %s", $time, m);
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
            fail($sformatf("byte %h exp %h", got, exp));
    endtask
    task automatic chk_addr(input logic [12:0] got, input logic [12:0] exp);
        num_checks++;
        if (got !== exp)
            fail($sformatf("address %h exp %h", got, exp));
    endtask
    task automatic chk_cnt(input int got, input int exp);
        num_checks++;
        if (got != exp)
            fail($sformatf("count %0d exp %0d", got, exp));
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic end_sim;
        $display("checks %0d, miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic par(input hbp_row_s r);
        int   w0 = wr_cnt;
        int   r0 = rd_cnt;
        logic go = !r.csn;
        @(posedge clk_sys);
        style <= r.sty;
        @(posedge clk_sys);
        cs_n    <= r.csn;
        addr    <= r.a;
        host_d  <= r.d;
        host_oe <= r.wr ? 8'hFF : 8'h00;
        rd_n    <= r.sty ? 1'b0 : r.wr;
        wr_n    <= !r.wr;
        tick(4);
        #1;
        chk_byte(data_oe, (go && !r.wr) ? 8'hFF : 8'h00);
        if (go && !r.wr) chk_byte(data_w, r.d);
        @(posedge clk_sys);
        rd_n    <= 1'b1;
        wr_n    <= 1'b1;
        host_oe <= 8'h00;
        tick(1);
        cs_n <= 1'b1;
        tick(4);
        #1;
        chk_cnt(wr_cnt - w0, int'(go && r.wr));
        chk_cnt(rd_cnt - r0, int'(go && !r.wr));
        if (go && r.wr) chk_addr(wr_addr, r.a);
        if (go && r.wr) chk_byte(wr_data, r.d);
        if (go && !r.wr) chk_addr(rd_addr, r.a);
    endtask

    task automatic ser_frame(input logic cpol, cpha, msb, rw, input logic [12:0] a,
                             input logic [7:0] d);
        int          w0 = wr_cnt;
        int          r0 = rd_cnt;
        logic [22:0] f = '0;
        logic [7:0]  got = '0;
        f[0] = rw;
        for (int k = 0; k < 13; k++) f[1 + k] = a[msb ? 12 - k : k];
        for (int k = 0; k < 8; k++) f[15 + k] = d[msb ? 7 - k : k];
        @(posedge clk_sys);
        ser     <= 1'b1;
        host_oe <= 8'hFE;
        // config pins stay put for the whole session
        host_d  <= {cpol, cpha, msb, 2'b00, cpol, 2'b00};
        tick(4);
        cs_n <= 1'b0;
        tick(4);
        // mosi moves only between edges, clear of both sample edges
        for (int k = 0; k < 23; k++)
        begin
            host_d[1] <= f[k];
            tick(4);
            if (!cpha && k > 14) got[msb ? 22 - k : k - 15] = data_w[0];
            if (k == 10) chk_byte(data_oe, 8'h01);
            host_d[2] <= !cpol;
            tick(4);
            if (cpha && k > 14) got[msb ? 22 - k : k - 15] = data_w[0];
            host_d[2] <= cpol;
            tick(4);
        end
        tick(8);
        cs_n <= 1'b1;
        tick(2);
        ser     <= 1'b0;
        host_oe <= 8'h00;
        tick(4);
        chk_cnt(wr_cnt - w0, int'(!rw));
        chk_cnt(rd_cnt - r0, int'(rw));
        if (rw) chk_addr(rd_addr, a);
        if (rw) chk_byte(got, d);
        if (!rw) chk_addr(wr_addr, a);
        if (!rw) chk_byte(wr_data, d);
    endtask

    initial
    begin
        tick(3);
        #1;
        chk_byte(data_oe, 8'h00);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        foreach (rows[i]) par(rows[i]);
        for (int m = 0; m < 4; m++)
        begin
            ser_frame(m[1], m[0], m[1] ^ m[0], 1'b0, 13'h1234 + 13'(m), 8'h96 ^ 8'(m));
            ser_frame(m[1], m[0], m[1] ^ m[0], 1'b1, 13'h1234 + 13'(m), 8'h96 ^ 8'(m));
        end
        // reset in mid-read must free the pins at once
        @(posedge clk_sys);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        tick(4);
        rst_n <= 1'b0;
        #1;
        chk_byte(data_oe, 8'h00);
        @(posedge clk_sys);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        tick(3);
        rst_n <= 1'b1;
        tick(4);
        chk_cnt(oe_err, 0);
        end_sim();
    end

    initial
    begin
        #100000;
        fail("watchdog expired");
        end_sim();
    end
endmodule
